// ### hdl/lcd_out_pkg.sv
package lcd_out_pkg;

    localparam int WORD_BITS = 32;
    localparam int QUAD_BITS = 128;
    localparam logic [1:0] LAST_WORD = 2'h3;
    localparam int CURSOR_WIDTH = 32;
    localparam int RASTER_W = 10;
    localparam int COL_W = 10;
    localparam int PIX_IDX_W = 7;
    localparam logic [PIX_IDX_W-1:0] IDX_MAX_1BPP = 7'h7F;

    ////////////////////////////////////////////////////////////////////////
    localparam int LUT_AW = 5;
    localparam int LUT_DW = 8;
    localparam int LUT_DEPTH = 32;
    localparam int NUM_LUTS = 3;
    localparam logic [1:0] LUT_GREEN = 2'h0;
    localparam logic [1:0] LUT_RED = 2'h1;
    localparam logic [1:0] LUT_EXT = 2'h2;
    localparam logic [2:0] CURSOR_LUT_BASE = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [1:0] SRC_GREEN = 2'h0;
    localparam logic [1:0] SRC_RED_GREEN = 2'h1;
    localparam logic [1:0] SRC_GREEN_EXT = 2'h2;

    localparam logic [1:0] BPP_1 = 2'h0;
    localparam logic [1:0] BPP_2 = 2'h1;
    localparam logic [1:0] BPP_4 = 2'h2;

    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [3:0] FRAME_STEP = 4'h1;

    typedef enum logic [1:0] {DMA_IDLE, DMA_SCREEN, DMA_CURSOR} dma_state_t;

endpackage

// ### hdl/lut_ram.sv
`timescale 1ns/10ps
// written on the control clock, read on the pixel clock; entries are
// quasi-static, so software only rewrites them outside active display
module lut_ram
    import lcd_out_pkg::*;
(
    input wire logic wrClk,
    input wire logic we,
    input wire logic [LUT_AW-1:0] wrAddr,
    input wire logic [LUT_DW-1:0] wrData,
    input wire logic rdClk,
    input wire logic [LUT_AW-1:0] rdAddr,
    output logic [LUT_DW-1:0] rdData
);

    logic [LUT_DW-1:0] mem [LUT_DEPTH];

    always_ff @(posedge wrClk)
    begin
        if (we)
            mem[wrAddr] <= wrData;
    end

    always_ff @(posedge rdClk)
    begin
        rdData <= mem[rdAddr];
    end

endmodule // lut_ram

// ### hdl/grey_scaler.sv
`timescale 1ns/10ps
// temporal modulation: a level is lit in `level` frames out of 16
module grey_scaler
    import lcd_out_pkg::*;
(
    input wire logic enable,
    input wire logic [3:0] level,
    input wire logic [3:0] frameCnt,
    output logic pixelOn
);

    always_comb
    begin
        if (enable)
            pixelOn = (level > frameCnt);
        else
            pixelOn = level[3];
    end

endmodule // grey_scaler

// ### hdl/lcd_output_path.sv
// Functional notes
// [RQ1] port source is green, red plus green, or green plus external LUT
// [RQ2] green and external LUT data optionally pass the frame grey scaler
// [RQ3] grey scaler turns 4-bit level into 1-bit pulse-width pixel, 16 levels
// [RQ4] 4 bpp quad-word holds 32 pixels, first pixel in lowest nybble
// [RQ5] software orders dual-panel quad-words upper and lower alternately
// [RQ6] dual panel: upper via green LUT low nybble, lower via external LUT
// [RQ7] dual panel byte: lower half bits 0 to 3, upper half bits 4 to 7
// [RQ8] single panel uses only the upper four port bits; the code zeroes bits 0 to 3 only for source green, whatever dualPanel is
// [RQ9] port clock runs at a quarter of the pixel rate, one byte per clock
// [RQ10] separate screen and cursor DMA requests, each a quad-word block; a dual panel screen request runs on for two quad-words
// [RQ11] cursor 32 pixels wide, 2 bpp, any height, same output path
// [RQ12] cursor quad-word fetched every second raster between start and end
// [RQ13] software supplies a line-offset cursor image for odd start rasters
// [RQ14] cursor code zero is transparent, screen pixel shows through
// [RQ15] port outputs can be forced to zero and held there
// [RQ16] 1 and 2 bpp modes map through palette onto the grey scaler
// [RQ17] software sets cursor start and end for cursors across the join
// [RQ18] port updates once per port clock, stable around the rising edge
`timescale 1ns/10ps
module lcd_output_path
    import lcd_out_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pixelClk,
    input wire logic [1:0] outputSourceSelect,
    input wire logic greyEnable,
    input wire logic dualPanel,
    input wire logic [1:0] bppMode,
    input wire logic forceZero,
    input wire logic [RASTER_W-1:0] cursorStartRaster,
    input wire logic [RASTER_W-1:0] cursorEndRaster,
    input wire logic lutWe,
    input wire logic [1:0] lutSel,
    input wire logic [LUT_AW-1:0] lutAddr,
    input wire logic [LUT_DW-1:0] lutData,
    output logic screenDmaReq,
    output logic cursorDmaReq,
    input wire logic dmaWordValid,
    input wire logic [WORD_BITS-1:0] dmaWord,
    input wire logic frameStart,
    input wire logic lineStart,
    input wire logic displayActive,
    input wire logic [RASTER_W-1:0] rasterNum,
    input wire logic [COL_W-1:0] cursorX,
    output logic [7:0] panelDataPort,
    output logic panelShiftClock
);

    typedef struct packed {
        logic [1:0] src;
        logic grey;
        logic [1:0] bpp;
        logic zero;
        logic [RASTER_W-1:0] cStart;
        logic [RASTER_W-1:0] cEnd;
    } cfg_t;

    typedef struct packed {
        dma_state_t st;
        logic [1:0] wordCnt;
        logic half;
        logic [2*QUAD_BITS-1:0] scrBuf;
        logic [QUAD_BITS-1:0] curBuf;
        logic scrFill;
        logic curFill;
        logic scrTakeS1;
        logic scrTakeS2;
        logic curNeedS1;
        logic curNeedS2;
        logic scrReq;
        logic curReq;
    } sys_t;

    typedef struct packed {
        logic rstS1;
        logic rstS2;
        cfg_t cfgS1;
        cfg_t cfgS2;
        logic scrFillS1;
        logic scrFillS2;
        logic curFillS1;
        logic curFillS2;
        logic scrTake;
        logic curNeed;
        logic curGot;
        logic curValid;
        logic [QUAD_BITS-1:0] upQ;
        logic [QUAD_BITS-1:0] loQ;
        logic [QUAD_BITS-1:0] curQ;
        logic [PIX_IDX_W-1:0] pixIdx;
        logic curLineOdd;
        logic curShow;
        logic [COL_W-1:0] col;
        logic [3:0] frameCnt;
        logic [1:0] ph;
        logic v1;
        logic [1:0] ph1;
        logic ok1;
        logic [3:0] upSh;
        logic [3:0] loSh;
        logic [1:0] oph;
        logic [7:0] port;
        logic sclk;
    } link_t;

    sys_t sys_r;
    sys_t sys_nxt;
    link_t lnk_r;
    link_t lnk_nxt;
    cfg_t cfgIn;

    logic [3:0] upNib;
    logic [3:0] loNib;
    logic [1:0] curCode;
    logic [COL_W-1:0] colOff;
    logic [LUT_AW-1:0] upAddr;
    logic [LUT_AW-1:0] loAddr;
    logic avail;
    logic pixOk;
    logic lastPix;
    logic xferLine;
    logic byteLoad;
    logic greenBit;
    logic extBit;
    logic upBit;
    logic loBit;
    logic [3:0] newUp;
    logic [3:0] newLo;
    logic [LUT_DW-1:0] lutRd [NUM_LUTS];

    // pixel width follows the mode; first pixel sits in the lowest bits
    function automatic logic [3:0] pixField(
        input logic [QUAD_BITS-1:0] q,
        input logic [PIX_IDX_W-1:0] idx,
        input logic [1:0] b
    );
        logic [QUAD_BITS-1:0] sh;
        sh = q >> ({2'h0, idx} << b);
        unique case (b)
            BPP_1: pixField = {3'h0, sh[0]};
            BPP_2: pixField = {2'h0, sh[1:0]};
            default: pixField = sh[3:0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control clock: dma fetch into quad-word holding buffers

    always_comb
    begin
        sys_nxt = sys_r;
        sys_nxt.scrTakeS1 = lnk_r.scrTake;
        sys_nxt.scrTakeS2 = sys_r.scrTakeS1;
        sys_nxt.curNeedS1 = lnk_r.curNeed;
        sys_nxt.curNeedS2 = sys_r.curNeedS1;
        unique case (sys_r.st)
            DMA_IDLE:
            begin
                sys_nxt.wordCnt = 2'h0;
                sys_nxt.half = 1'b0;
                // cursor first: it is needed within the current raster
                if (sys_r.curNeedS2 != sys_r.curFill)
                begin
                    sys_nxt.st = DMA_CURSOR;
                    sys_nxt.curReq = 1'b1; // see [RQ10]
                end
                else if (sys_r.scrTakeS2 == sys_r.scrFill)
                begin
                    sys_nxt.st = DMA_SCREEN;
                    sys_nxt.scrReq = 1'b1; // see [RQ10]
                end
            end
            DMA_SCREEN:
            begin
                if (dmaWordValid)
                begin
                    sys_nxt.scrBuf[{sys_r.half, sys_r.wordCnt, 5'h00}
                        +: WORD_BITS] = dmaWord;
                    sys_nxt.wordCnt = sys_r.wordCnt + 2'h1;
                    if (sys_r.wordCnt == LAST_WORD)
                    begin
                        if (dualPanel && !sys_r.half)
                            sys_nxt.half = 1'b1; // see [RQ5]
                        else
                        begin
                            sys_nxt.scrReq = 1'b0;
                            sys_nxt.scrFill = ~sys_r.scrFill;
                            sys_nxt.st = DMA_IDLE;
                        end
                    end
                end
            end
            DMA_CURSOR:
            begin
                if (dmaWordValid)
                begin
                    sys_nxt.curBuf[{sys_r.wordCnt, 5'h00} +: WORD_BITS] =
                        dmaWord;
                    sys_nxt.wordCnt = sys_r.wordCnt + 2'h1;
                    if (sys_r.wordCnt == LAST_WORD)
                    begin
                        sys_nxt.curReq = 1'b0;
                        sys_nxt.curFill = ~sys_r.curFill;
                        sys_nxt.st = DMA_IDLE;
                    end
                end
            end
            default: sys_nxt.st = DMA_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            sys_r <= '0;
        else
            sys_r <= sys_nxt;
    end

    assign screenDmaReq = sys_r.scrReq;
    assign cursorDmaReq = sys_r.curReq;

    ////////////////////////////////////////////////////////////////////////
    // look-up tables, one per source, and the two grey scalers

    for (genvar g = 0; g < NUM_LUTS; g++)
    begin : gLut
        lut_ram uLut (
            .wrClk(clk),
            .we(lutWe && (lutSel == 2'(g))),
            .wrAddr(lutAddr),
            .wrData(lutData),
            .rdClk(pixelClk),
            .rdAddr((2'(g) == LUT_EXT) ? loAddr : upAddr), // see [RQ6]
            .rdData(lutRd[g])
        );
    end

    grey_scaler uGreyUp (
        .enable(lnk_r.cfgS2.grey),
        .level(lutRd[LUT_GREEN][3:0]), // see [RQ6]
        .frameCnt(lnk_r.frameCnt),
        .pixelOn(greenBit)
    );

    grey_scaler uGreyLo (
        .enable(lnk_r.cfgS2.grey),
        .level(lutRd[LUT_EXT][3:0]),
        .frameCnt(lnk_r.frameCnt),
        .pixelOn(extBit)
    );

    ////////////////////////////////////////////////////////////////////////
    // pixel clock: unpack, cursor overlay, byte assembly, port clock

    assign cfgIn = '{src: outputSourceSelect, grey: greyEnable,
        bpp: bppMode, zero: forceZero, cStart: cursorStartRaster,
        cEnd: cursorEndRaster};

    always_comb
    begin
        lnk_nxt = lnk_r;
        upNib = pixField(lnk_r.upQ, lnk_r.pixIdx, lnk_r.cfgS2.bpp);
        loNib = pixField(lnk_r.loQ, lnk_r.pixIdx, lnk_r.cfgS2.bpp);
        colOff = lnk_r.col - cursorX;
        curCode = lnk_r.curQ[{lnk_r.curLineOdd, colOff[4:0], 1'b0} +: 2];
        if (!lnk_r.curShow || !lnk_r.curGot ||
            colOff >= COL_W'(CURSOR_WIDTH))
            curCode = 2'h0; // see [RQ11]
        // a zero code keeps the screen address, so it is transparent
        upAddr = (curCode != 2'h0) ? {CURSOR_LUT_BASE, curCode}
                                   : {1'b0, upNib}; // see [RQ14]
        loAddr = (curCode != 2'h0) ? {CURSOR_LUT_BASE, curCode}
                                   : {1'b0, loNib};
        avail = (lnk_r.scrFillS2 != lnk_r.scrTake);
        pixOk = displayActive && lnk_r.curValid;
        lastPix = (lnk_r.pixIdx == (IDX_MAX_1BPP >> lnk_r.cfgS2.bpp));
        xferLine = !rasterNum[0] &&
            ({1'b0, rasterNum} + 11'h001 >= {1'b0, lnk_r.cfgS2.cStart}) &&
            (rasterNum <= lnk_r.cfgS2.cEnd); // see [RQ12]
        upBit = lnk_r.ok1 && greenBit; // see [RQ2]
        if (lnk_r.cfgS2.src == SRC_RED_GREEN)
            loBit = lnk_r.ok1 && lutRd[LUT_RED][3];
        else
            loBit = lnk_r.ok1 && extBit;
        newUp = {lnk_r.upSh[2:0], upBit};
        newLo = {lnk_r.loSh[2:0], loBit};
        byteLoad = lnk_r.v1 && (lnk_r.ph1 == PHASE_LAST); // see [RQ9]

        lnk_nxt.cfgS1 = cfgIn;
        lnk_nxt.cfgS2 = lnk_r.cfgS1;
        lnk_nxt.scrFillS1 = sys_r.scrFill;
        lnk_nxt.scrFillS2 = lnk_r.scrFillS1;
        lnk_nxt.curFillS1 = sys_r.curFill;
        lnk_nxt.curFillS2 = lnk_r.curFillS1;

        // the buffer is stable here: it is refilled only after the take
        if (avail && (!lnk_r.curValid ||
            (displayActive && lastPix)))
        begin
            lnk_nxt.upQ = sys_r.scrBuf[QUAD_BITS-1:0]; // see [RQ4]
            lnk_nxt.loQ = sys_r.scrBuf[2*QUAD_BITS-1:QUAD_BITS];
            lnk_nxt.scrTake = ~lnk_r.scrTake;
            lnk_nxt.curValid = 1'b1;
            lnk_nxt.pixIdx = '0;
        end
        else if (pixOk)
        begin
            lnk_nxt.pixIdx = lnk_r.pixIdx + 7'h01;
            if (lastPix)
                lnk_nxt.curValid = 1'b0; // underflow shows dark pixels
        end

        if (!lnk_r.curGot && (lnk_r.curFillS2 == lnk_r.curNeed))
        begin
            lnk_nxt.curQ = sys_r.curBuf;
            lnk_nxt.curGot = 1'b1;
        end

        if (frameStart)
            lnk_nxt.frameCnt = lnk_r.frameCnt + FRAME_STEP; // see [RQ3]

        if (lineStart)
        begin
            lnk_nxt.col = '0;
            lnk_nxt.ph = 2'h0;
            lnk_nxt.curLineOdd = rasterNum[0];
            lnk_nxt.curShow = (rasterNum >= lnk_r.cfgS2.cStart) &&
                (rasterNum <= lnk_r.cfgS2.cEnd);
            if (xferLine)
            begin
                lnk_nxt.curNeed = ~lnk_r.curNeed; // see [RQ12]
                lnk_nxt.curGot = 1'b0;
            end
        end
        else if (displayActive)
        begin
            lnk_nxt.col = lnk_r.col + 10'h001;
            lnk_nxt.ph = lnk_r.ph + 2'h1;
        end

        lnk_nxt.v1 = displayActive && !lineStart;
        lnk_nxt.ph1 = lnk_r.ph;
        lnk_nxt.ok1 = pixOk;
        if (lnk_r.v1)
        begin
            lnk_nxt.upSh = newUp;
            lnk_nxt.loSh = newLo;
        end

        if (byteLoad)
        begin
            unique case (lnk_r.cfgS2.src) // see [RQ1]
                SRC_GREEN: lnk_nxt.port = {newUp, 4'h0}; // see [RQ8]
                SRC_RED_GREEN: lnk_nxt.port = {newUp, newLo};
                SRC_GREEN_EXT: lnk_nxt.port = {newUp, newLo}; // see [RQ7]
                default: lnk_nxt.port = 8'h00;
            endcase
            lnk_nxt.oph = 2'h0; // see [RQ18]
        end
        else
            lnk_nxt.oph = lnk_r.oph + 2'h1;
        if (lnk_r.cfgS2.zero)
            lnk_nxt.port = 8'h00; // see [RQ15]
        // data change with the clock low, rising edge two cycles later
        lnk_nxt.sclk = lnk_nxt.oph[1]; // see [RQ18]

        if (lnk_r.rstS2)
        begin
            lnk_nxt = '0;
            lnk_nxt.cfgS1 = cfgIn;
        end
        lnk_nxt.rstS1 = rst;
        lnk_nxt.rstS2 = lnk_r.rstS1;
    end

    always_ff @(posedge pixelClk)
    begin
        lnk_r <= lnk_nxt;
    end

    assign panelDataPort = lnk_r.port;
    assign panelShiftClock = lnk_r.sclk;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence sClkLowPair;
        !panelShiftClock ##1 !panelShiftClock;
    endsequence

    sequence sNoLoad3;
        !byteLoad [*3];
    endsequence

    a_port_edge_setup: assert property ( // see [RQ18]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        $changed(panelDataPort) && !$past(lnk_r.cfgS2.zero)
        |-> sClkLowPair ##1 panelShiftClock)
        else $error("port changed too close to the shift clock edge");

    a_byte_spacing: assert property ( // see [RQ9]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        byteLoad && !lineStart |=> sNoLoad3)
        else $error("port bytes closer than four pixel clocks");

    a_force_zero: assert property ( // see [RQ15]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        lnk_r.cfgS2.zero |=> panelDataPort == 8'h00)
        else $error("port not held at zero while forced");

    a_single_upper: assert property ( // see [RQ8]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        byteLoad && lnk_r.cfgS2.src == SRC_GREEN
        |=> panelDataPort[3:0] == 4'h0)
        else $error("single panel drove the low port bits");

    a_dual_halves: assert property ( // see [RQ7]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        byteLoad && lnk_r.cfgS2.src == SRC_GREEN_EXT && !lnk_r.cfgS2.zero
        |=> panelDataPort == {$past(newUp), $past(newLo)})
        else $error("dual panel halves in the wrong port bits");

    a_grey_dark: assert property ( // see [RQ3]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        lnk_r.cfgS2.grey && lutRd[LUT_GREEN][3:0] == 4'h0 |-> !upBit)
        else $error("grey level zero produced a lit pixel");

    a_cursor_even: assert property ( // see [RQ12]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        $changed(lnk_r.curNeed) |-> $past(lineStart) && !$past(rasterNum[0]))
        else $error("cursor fetch requested on an odd raster");

    a_cursor_hidden: assert property ( // see [RQ14]
        @(posedge pixelClk) disable iff (lnk_r.rstS2)
        !lnk_r.curShow |-> !upAddr[LUT_AW-1] && !loAddr[LUT_AW-1])
        else $error("cursor colour used outside the cursor rasters");

    a_req_single: assert property ( // see [RQ10]
        @(posedge clk) disable iff (rst)
        !(screenDmaReq && cursorDmaReq))
        else $error("screen and cursor requests raised together");

    a_cursor_quad: assert property ( // see [RQ10]
        @(posedge clk) disable iff (rst)
        cursorDmaReq && dmaWordValid && sys_r.wordCnt == LAST_WORD
        |=> !cursorDmaReq && $changed(sys_r.curFill))
        else $error("cursor block not closed after four words");

    a_dual_fetch: assert property ( // see [RQ5]
        @(posedge clk) disable iff (rst)
        screenDmaReq && dmaWordValid && dualPanel && !sys_r.half &&
        sys_r.wordCnt == LAST_WORD |=> screenDmaReq && sys_r.half)
        else $error("dual panel did not fetch the lower quad-word");

endmodule // lcd_output_path

// ### testbench/stn_panel_model.sv
`timescale 1ns/10ps
// passive panel: latches the port on each rising shift clock edge while
// its display enable is high, and checks set-up time and clock period
module stn_panel_model
(
    input wire logic panelShiftClock,
    input wire logic [7:0] panelDataPort,
    input wire logic displayEn,
    output logic [7:0] gotByte,
    output int gotCnt,
    output int badTiming
);
    realtime lastChange = 0.0;
    realtime lastRise = 0.0;
    logic inRun = 1'b0;

    initial
    begin
        gotByte = 8'h00;
        gotCnt = 0;
        badTiming = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(panelDataPort)
        lastChange = $realtime;

    always @(negedge displayEn)
        inRun = 1'b0;

    always @(posedge panelShiftClock)
    begin
        if (displayEn)
        begin
            // a byte must settle at least one link cycle before its edge
            if ($realtime - lastChange < 11.0)
                badTiming++;
            // one byte every four pixels inside a line
            if (inRun && ($realtime - lastRise < 47.5 ||
                          $realtime - lastRise > 48.5))
                badTiming++;
            inRun = 1'b1;
            lastRise = $realtime;
            gotByte = panelDataPort;
            gotCnt++;
        end
    end
endmodule // stn_panel_model

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`define CHECK(nm, e, g) \
    begin \
        testsRun++; \
        if ((g) !== (e)) \
        begin \
            errCount++; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end

module tb_top
    import lcd_out_pkg::*;
;
    logic clk = 1'b0, pixelClk = 1'b0, rst = 1'b1;
    logic [1:0] outputSourceSelect = 2'h0, lutSel = 2'h0;
    logic greyEnable = 1'b0, dualPanel = 1'b0, forceZero = 1'b0;
    logic lutWe = 1'b0, dmaWordValid = 1'b0, frameStart = 1'b0;
    logic lineStart = 1'b0, displayActive = 1'b0, displayEn = 1'b0;
    logic [LUT_AW-1:0] lutAddr = 5'h00;
    logic [LUT_DW-1:0] lutData = 8'h00;
    logic [WORD_BITS-1:0] dmaWord = 32'h0, lfsrState = 32'h863F;
    logic [RASTER_W-1:0] rasterNum = 10'h000;
    wire logic screenDmaReq, cursorDmaReq, panelShiftClock;
    wire logic [7:0] panelDataPort, gotByte;
    int gotCnt, badTiming, errCount = 0, testsRun = 0, cyc = 0;
    logic [QUAD_BITS-1:0] upQ[$], loQ[$];
    logic [7:0] expQ[$], expByte;
    logic cursorSeen = 1'b0;
    logic [3:0] fcnt = 4'h0;
    // {force, grey, source} per line; single panel phase, then dual
    logic [3:0] cfgTbl [2][5] = '{'{4'h0, 4'h1, 4'h4, 4'h3, 4'h0},
                                 '{4'h2, 4'h6, 4'h6, 4'hA, 4'h2}};

    always #12.5 clk = ~clk;
    always #6 pixelClk = ~pixelClk;

    lcd_output_path u_lcd_output_path (
        .clk(clk), .rst(rst), .pixelClk(pixelClk),
        .outputSourceSelect(outputSourceSelect), .greyEnable(greyEnable),
        .dualPanel(dualPanel), .bppMode(BPP_4), .forceZero(forceZero),
        .cursorStartRaster(10'h000),
        .cursorEndRaster(10'h007),
        .lutWe(lutWe), .lutSel(lutSel), .lutAddr(lutAddr),
        .lutData(lutData), .screenDmaReq(screenDmaReq),
        .cursorDmaReq(cursorDmaReq), .dmaWordValid(dmaWordValid),
        .dmaWord(dmaWord), .frameStart(frameStart), .lineStart(lineStart),
        .displayActive(displayActive), .rasterNum(rasterNum),
        .cursorX(10'h000), .panelDataPort(panelDataPort),
        .panelShiftClock(panelShiftClock));

    stn_panel_model u_stn_panel_model (
        .panelShiftClock(panelShiftClock), .panelDataPort(panelDataPort),
        .displayEn(displayEn), .gotByte(gotByte), .gotCnt(gotCnt),
        .badTiming(badTiming));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic lit(input logic [7:0] e, input logic grey);
        return grey ? (e[3:0] > fcnt) : e[3];
    endfunction

    // lut entries: green = v, red = v ^ C (never grey scaled), ext = ~v
    function automatic logic [7:0] predict(input logic [QUAD_BITS-1:0] u,
        input logic [QUAD_BITS-1:0] l, input logic [3:0] c, input int g);
        logic [7:0] b;
        logic [3:0] vu, vl;
        b = 8'h00;
        for (int k = 0; k < 4; k++)
        begin
            vu = u[16*g+4*k +: 4];
            vl = l[16*g+4*k +: 4];
            b[7-k] = lit({4'h0, vu}, c[2]);
            b[3-k] = (c[1:0] == SRC_RED_GREEN) ? ~vu[3] :
                     (c[1:0] == SRC_GREEN_EXT) ? lit({4'h0, ~vl}, c[2]) :
                     1'b0;
        end
        if (c[3] || c[1:0] == 2'h3)
            b = 8'h00;
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic lutWrite(input logic [1:0] s, input int a,
                            input logic [3:0] d);
        @(posedge clk);
        #1;
        lutWe = 1'b1;
        lutSel = s;
        lutAddr = a[4:0];
        lutData = {4'h0, d};
        @(posedge clk);
        #1;
        lutWe = 1'b0;
    endtask

    task automatic doReset;
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        upQ.delete();
        loQ.delete();
        fcnt = 4'h0;
        repeat (20) @(posedge clk);
    endtask

    // dma partner: screen blocks get lfsr data, cursor blocks all zero
    task automatic serveBlock;
        logic cur;
        int n;
        logic [255:0] blk;
        cur = cursorDmaReq;
        n = (cur || !dualPanel) ? 4 : 8;
        blk = '0;
        for (int w = 0; w < n; w++)
        begin
            dmaWordValid = 1'b1;
            dmaWord = cur ? 32'h0 : lfsrState;
            lfsrState = nextRand(lfsrState);
            blk[32*w +: 32] = dmaWord;
            @(posedge clk);
            #1;
            if (rst)
                break;
        end
        dmaWordValid = 1'b0;
        if (!rst && cur)
            cursorSeen = 1'b1;
        else if (!rst)
        begin
            upQ.push_back(blk[127:0]);
            loQ.push_back(blk[255:128]);
        end
    endtask

    always
    begin
        @(posedge clk);
        #1;
        if ((screenDmaReq || cursorDmaReq) && !rst)
            serveBlock();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic runLine(input logic [3:0] c, input int r);
        logic [QUAD_BITS-1:0] u, l;
        int k;
        @(posedge clk);
        #1;
        {forceZero, greyEnable, outputSourceSelect} = c;
        k = 0;
        while (upQ.size() == 0 && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        `CHECK("screen fetch", 1'b1, upQ.size() > 0)
        if (upQ.size() == 0)
            return;
        u = upQ.pop_front();
        l = loQ.pop_front();
        cursorSeen = 1'b0;
        repeat (20) @(posedge clk);
        @(posedge pixelClk);
        #1;
        rasterNum = r[9:0];
        frameStart = 1'b1;
        fcnt++;
        @(posedge pixelClk);
        #1;
        frameStart = 1'b0;
        lineStart = 1'b1;
        @(posedge pixelClk);
        #1;
        lineStart = 1'b0;
        repeat (3) @(posedge pixelClk);
        // enable window keeps free-running shift edges out of the capture
        for (int j = 0; j < 40; j++)
        begin
            @(posedge pixelClk);
            #1;
            displayActive = (j < 32);
            displayEn = (j >= 5 && j <= 37);
            if (j % 4 == 0 && j < 32)
                expQ.push_back(predict(u, l, c, j / 4));
        end
        repeat (30) @(posedge clk);
        `CHECK("cursor fetch", r == 0, cursorSeen)
    endtask

    always @(gotCnt)
    begin
        if (gotCnt > 0)
        begin
            if (expQ.size() > 0)
            begin
                expByte = expQ.pop_front();
                `CHECK("panel byte", expByte, gotByte)
            end
            else
                `CHECK("extra byte", 1'b0, 1'b1)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic giveVerdict;
        $display("Checks run %0d, mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // the run needs about a thousand cycles; this ceiling only cuts a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errCount++;
            giveVerdict();
        end
    end

    initial
    begin
        doReset();
        for (int i = 0; i < 16; i++)
        begin
            lutWrite(LUT_GREEN, i, i[3:0]);
            lutWrite(LUT_RED, i, i[3:0] ^ 4'hC);
            lutWrite(LUT_EXT, i, ~i[3:0]);
        end
        for (int ph = 0; ph < 2; ph++)
        begin
            dualPanel = ph[0];
            doReset();
            for (int li = 0; li < 5; li++)
                runLine(cfgTbl[ph][li], li * 16);
        end
        repeat (50) @(posedge clk);
        `CHECK("bytes pending", 0, expQ.size())
        `CHECK("panel timing", 0, badTiming)
        giveVerdict();
    end
endmodule // tb_top
